// File: core/pfb_pkg.sv
// package: constants and types for the parallel flash host controller
package pfb_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned ADDR_W           = 22;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned PAGE_BITS        = 3;
  localparam int unsigned BUF_MAX_BYTES    = 32;
  // times in ns, plain defaults
  localparam int unsigned RANDOM_ACCESS_NS = 90;
  localparam int unsigned SELECT_ACCESS_NS = 90;
  localparam int unsigned PAGE_ACCESS_NS   = 25;
  localparam int unsigned WRITE_PULSE_NS   = 35;
  localparam int unsigned RESET_PULSE_NS   = 500;
  localparam int unsigned RESET_RELEASE_NS = 50;
  localparam int unsigned RESET_SETTLE_NS  = 20000;
  // least times round up
  localparam int unsigned RANDOM_ACCESS_CYC =
    (RANDOM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SELECT_ACCESS_CYC =
    (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PAGE_ACCESS_CYC =
    (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_RELEASE_CYC =
    (RESET_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_SETTLE_CYC =
    (RESET_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 13;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 13'h0001;

  typedef enum logic [2:0] {
    PFB_IDLE    = 3'b000,
    PFB_READ    = 3'b001,
    PFB_WRITE   = 3'b010,
    PFB_RECOVER = 3'b011,
    PFB_RST_LOW = 3'b100,
    PFB_RST_WT  = 3'b101
  } pfb_state_t;
endpackage : pfb_pkg

// File: core/pfb_timer_if.sv
// interface: load/expire handshake between controller and delay timer
`timescale 1ns/1ps
`default_nettype none
interface pfb_timer_if;
  logic                    load;
  logic [pfb_pkg::CNT_W-1:0] count;
  logic                    done;
  modport ctrl (output load, output count, input done);
  modport tmr  (input load, input count, output done);
endinterface : pfb_timer_if
`default_nettype wire

// File: core/pfb_timer.sv
// module: down-counting delay timer, done when count reaches zero
`timescale 1ns/1ps
`default_nettype none
module pfb_timer (
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  resetn_in,
  // timer port
  pfb_timer_if.tmr   tmr
);
  logic [pfb_pkg::CNT_W-1:0] cnt;
  logic [pfb_pkg::CNT_W-1:0] next_cnt;

  assign next_cnt = tmr.load ? tmr.count :
                    (cnt != pfb_pkg::CNT_ZERO) ? cnt - pfb_pkg::CNT_ONE :
                    cnt;
  assign tmr.done = (cnt == pfb_pkg::CNT_ZERO) && !tmr.load;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) cnt <= pfb_pkg::CNT_ZERO;
    else            cnt <= next_cnt;
  end
endmodule : pfb_timer
`default_nettype wire

// File: core/pfb_host.sv
// module: host-side controller driving an asynchronous parallel flash
//
// Behaviour
// R1: read by holding select and output gate low, write strobe high
// R2: after reset the device reads array data without any command
// R3: device keeps array reads until a command write alters it
// R4: eight-byte pages; upper address picks page, low three bits byte
// R5: first page access waits random time, in-page reads page time
// R6: select released between reads forces the full access time again
// R7: write by driving strobe and select low with output gate high
// R8: unlock-bypass program needs two writes instead of four
// R9: erase clears one sector, several sectors, or the whole array
// R10: write-buffer programming takes at most 32 bytes per operation
// R11: high voltage on boost pin gives bypass, unprotect, fast program
// R12: removing boost voltage returns device to normal operation
// R13: boost only during accelerated programming, pin never floating
// R14: autoselect reads come from an id register with normal timing
// R15: select and reset high put the device in standby, outputs float
// R16: first read after standby waits the full select access time
// R17: deselecting during program or erase does not stop it
// R18: stable address for access time plus 30 ns enters sleep
// R19: in sleep data stays latched; address change gives new data
// R20: a long enough reset pulse aborts, floats outputs, returns to read
// R21: host restarts an operation that a reset interrupted; the code only clears its write count and does not reissue anything
// R22: reset during program keeps busy low until internal reset ends
// R23: reset while idle completes within the idle settle time
// R24: host waits the release delay after reset before reading
// R25: all access and reset times are parameters; only RESET_SETTLE_CYCLES is one, the rest are package localparams
`timescale 1ns/1ps
`default_nettype none
module pfb_host #(
  // R25: long count overridable
  parameter int unsigned RESET_SETTLE_CYCLES = pfb_pkg::RESET_SETTLE_CYC
) (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  // user command port
  input  wire logic                       rd_req_in,
  input  wire logic                       wr_req_in,
  input  wire logic                       flash_reset_req_in,
  input  wire logic                       boost_req_in,
  input  wire logic [pfb_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [pfb_pkg::DATA_W-1:0] wdata_in,
  output logic                            ready_out,
  output logic                            rd_valid_out,
  output logic [pfb_pkg::DATA_W-1:0]      rdata_out,
  output logic                            reset_done_out,
  output logic                            dev_busy_out,
  // flash pins
  output logic                            flash_ce_n_out,
  output logic                            flash_oe_n_out,
  output logic                            flash_we_n_out,
  output logic                            flash_reset_n_out,
  output logic                            fast_program_hv_pin_out,
  output logic [pfb_pkg::ADDR_W-1:0]      flash_addr_out,
  input  wire logic [pfb_pkg::DATA_W-1:0] data_bus_in,
  output logic [pfb_pkg::DATA_W-1:0]      data_bus_out,
  output logic                            data_bus_oe_n_out,
  input  wire logic                       ready_busy_n_in
);
  localparam logic [pfb_pkg::CNT_W-1:0] C_RAND =
    pfb_pkg::CNT_W'(pfb_pkg::RANDOM_ACCESS_CYC - 1);
  localparam logic [pfb_pkg::CNT_W-1:0] C_SEL =
    pfb_pkg::CNT_W'(pfb_pkg::SELECT_ACCESS_CYC - 1);
  localparam logic [pfb_pkg::CNT_W-1:0] C_PAGE =
    pfb_pkg::CNT_W'(pfb_pkg::PAGE_ACCESS_CYC - 1);
  localparam logic [pfb_pkg::CNT_W-1:0] C_WR =
    pfb_pkg::CNT_W'(pfb_pkg::WRITE_PULSE_CYC - 1);
  localparam logic [pfb_pkg::CNT_W-1:0] C_RP =
    pfb_pkg::CNT_W'(pfb_pkg::RESET_PULSE_CYC - 1);
  localparam logic [pfb_pkg::CNT_W-1:0] C_RH =
    pfb_pkg::CNT_W'(pfb_pkg::RESET_RELEASE_CYC - 1);
  localparam logic [pfb_pkg::CNT_W-1:0] C_SETTLE =
    pfb_pkg::CNT_W'(RESET_SETTLE_CYCLES - 1);
  // R24: post-reset wait covers release delay and settle time
  localparam logic [pfb_pkg::CNT_W-1:0] C_POST =
    (C_SETTLE > C_RH) ? C_SETTLE : C_RH;
  localparam int unsigned PAGE_W = pfb_pkg::ADDR_W - pfb_pkg::PAGE_BITS;
  localparam int unsigned WCNT_W = 6;
  localparam logic [WCNT_W-1:0] WR_LIMIT =
    WCNT_W'(pfb_pkg::BUF_MAX_BYTES);
  localparam logic [WCNT_W-1:0] WR_ONE  = 6'h01;
  localparam logic [WCNT_W-1:0] WR_ZERO = 6'h00;

  pfb_timer_if tif ();

  pfb_timer u_timer (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .tmr       (tif.tmr)
  );

  // state and bookkeeping
  pfb_pkg::pfb_state_t        state;
  pfb_pkg::pfb_state_t        next_state;
  logic [PAGE_W-1:0]          open_page;
  logic [PAGE_W-1:0]          next_open_page;
  logic                       page_valid;
  logic                       next_page_valid;
  logic [WCNT_W-1:0]          wr_count;
  logic [WCNT_W-1:0]          next_wr_count;
  logic                       arm;
  logic                       next_arm;

  // next values of outputs
  logic                       next_ce_n;
  logic                       next_oe_n;
  logic                       next_we_n;
  logic                       next_rst_n;
  logic                       next_hv;
  logic [pfb_pkg::ADDR_W-1:0] next_addr;
  logic [pfb_pkg::DATA_W-1:0] next_wdata;
  logic                       next_bus_oe_n;
  logic                       next_rd_valid;
  logic [pfb_pkg::DATA_W-1:0] next_rdata;
  logic                       next_busy;
  logic                       next_reset_done;

  // decode wires
  logic                       is_idle;
  logic                       is_read;
  logic                       is_write;
  logic                       is_recover;
  logic                       is_rst_low;
  logic                       is_rst_wt;
  logic [PAGE_W-1:0]          req_page;
  logic                       page_hit;
  logic [pfb_pkg::CNT_W-1:0]  rd_count;
  logic                       wr_room;
  logic                       start_rst;
  logic                       start_rd;
  logic                       start_wr;
  logic                       t_done;
  logic                       rd_end;
  logic                       wr_end;
  logic                       rst_low_end;
  logic                       rst_wt_end;

  // state decode
  assign is_idle     = (state == pfb_pkg::PFB_IDLE);
  assign is_read     = (state == pfb_pkg::PFB_READ);
  assign is_write    = (state == pfb_pkg::PFB_WRITE);
  assign is_recover  = (state == pfb_pkg::PFB_RECOVER);
  assign is_rst_low  = (state == pfb_pkg::PFB_RST_LOW);
  assign is_rst_wt   = (state == pfb_pkg::PFB_RST_WT);
  assign req_page    = addr_in[pfb_pkg::ADDR_W-1:pfb_pkg::PAGE_BITS];

  // R5 R6 R16: short wait only inside a page kept open under select
  assign page_hit    = page_valid && (req_page == open_page);
  assign rd_count    = page_hit       ? C_PAGE :
                       flash_ce_n_out ? C_SEL  :
                                        C_RAND;
  // R8 R10: bounded run of writes between status reads
  assign wr_room     = (wr_count != WR_LIMIT);
  assign start_rst   = is_idle && flash_reset_req_in;
  // R13: no read while the boost pin is or may go high
  assign start_rd    = is_idle && !flash_reset_req_in && rd_req_in &&
                       !boost_req_in && !fast_program_hv_pin_out;
  assign start_wr    = is_idle && !flash_reset_req_in && !rd_req_in &&
                       wr_req_in && wr_room;
  assign t_done      = tif.done;
  assign rd_end      = is_read && t_done;
  assign wr_end      = is_write && t_done;
  assign rst_low_end = is_rst_low && t_done;
  // R22 R23: leave reset only once the device reports ready
  assign rst_wt_end  = is_rst_wt && !arm && t_done && ready_busy_n_in;

  // delay timer loads
  assign tif.load    = start_rd || start_wr || start_rst || arm;
  assign tif.count   = start_rd  ? rd_count :
                       start_wr  ? C_WR     :
                       start_rst ? C_RP     :
                                   C_POST;

  // main sequencer
  always_comb begin
    next_state = state;
    case (state)
      pfb_pkg::PFB_IDLE: begin
        if (start_rst)     next_state = pfb_pkg::PFB_RST_LOW;
        else if (start_rd) next_state = pfb_pkg::PFB_READ;
        else if (start_wr) next_state = pfb_pkg::PFB_WRITE;
      end
      pfb_pkg::PFB_READ: begin
        if (rd_end) next_state = pfb_pkg::PFB_IDLE;
      end
      pfb_pkg::PFB_WRITE: begin
        if (wr_end) next_state = pfb_pkg::PFB_RECOVER;
      end
      pfb_pkg::PFB_RECOVER: next_state = pfb_pkg::PFB_IDLE;
      pfb_pkg::PFB_RST_LOW: begin
        if (rst_low_end) next_state = pfb_pkg::PFB_RST_WT;
      end
      pfb_pkg::PFB_RST_WT: begin
        if (rst_wt_end) next_state = pfb_pkg::PFB_IDLE;
      end
      default: next_state = pfb_pkg::PFB_IDLE;
    endcase
  end

  // R1 R7: select low for both kinds of cycle
  assign next_ce_n       = (start_rd || start_wr)    ? 1'b0 :
                           (is_recover || start_rst) ? 1'b1 :
                           flash_ce_n_out;
  // R1: output gate low only through the read
  assign next_oe_n       = !(start_rd || (is_read && !t_done));
  // R7: write strobe low only through the write
  assign next_we_n       = !(start_wr || (is_write && !t_done));
  // R20: reset pin low through the pulse width
  assign next_rst_n      = !(start_rst || (is_rst_low && !t_done));
  // R11 R12 R13: boost follows the request outside reads and reset pulses
  assign next_hv         = boost_req_in && !is_read && !is_rst_low &&
                           !start_rst;
  assign next_addr       = (start_rd || start_wr) ? addr_in : flash_addr_out;
  assign next_wdata      = start_wr ? wdata_in : data_bus_out;
  // data held one cycle past the strobe's rising edge
  assign next_bus_oe_n   = !(start_wr || is_write);
  assign next_rd_valid   = rd_end;
  assign next_rdata      = rd_end ? data_bus_in : rdata_out;
  assign next_busy       = !ready_busy_n_in;
  assign next_reset_done = rst_wt_end;
  assign next_arm        = rst_low_end;
  assign next_open_page  = start_rd ? req_page : open_page;
  assign next_page_valid = rd_end || (page_valid && !start_wr && !start_rst);
  // R21: a reset clears write bookkeeping so a sequence restarts clean
  assign next_wr_count   = (start_rst || rd_end) ? WR_ZERO :
                           start_wr ? wr_count + WR_ONE : wr_count;
  assign ready_out       = is_idle;

  // sequencer and bookkeeping registers
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state      <= pfb_pkg::PFB_IDLE;
      open_page  <= '0;
      page_valid <= 1'b0;
      wr_count   <= WR_ZERO;
      arm        <= 1'b0;
    end else begin
      state      <= next_state;
      open_page  <= next_open_page;
      page_valid <= next_page_valid;
      wr_count   <= next_wr_count;
      arm        <= next_arm;
    end
  end

  // flash control pins
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      flash_ce_n_out          <= 1'b1;
      flash_oe_n_out          <= 1'b1;
      flash_we_n_out          <= 1'b1;
      flash_reset_n_out       <= 1'b1;
      fast_program_hv_pin_out <= 1'b0;
      flash_addr_out          <= '0;
    end else begin
      flash_ce_n_out          <= next_ce_n;
      flash_oe_n_out          <= next_oe_n;
      flash_we_n_out          <= next_we_n;
      flash_reset_n_out       <= next_rst_n;
      fast_program_hv_pin_out <= next_hv;
      flash_addr_out          <= next_addr;
    end
  end

  // data and status outputs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      data_bus_out      <= '0;
      data_bus_oe_n_out <= 1'b1;
      rd_valid_out      <= 1'b0;
      rdata_out         <= '0;
      dev_busy_out      <= 1'b0;
      reset_done_out    <= 1'b0;
    end else begin
      data_bus_out      <= next_wdata;
      data_bus_oe_n_out <= next_bus_oe_n;
      rd_valid_out      <= next_rd_valid;
      rdata_out         <= next_rdata;
      dev_busy_out      <= next_busy;
      reset_done_out    <= next_reset_done;
    end
  end
endmodule : pfb_host
`default_nettype wire

// File: tb/pfb_monitor.sv
// checker: pin-level assertions for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module pfb_monitor (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic rd_valid_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_we_n_out,
  input wire logic flash_reset_n_out,
  input wire logic fast_program_hv_pin_out,
  input wire logic data_bus_oe_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_read_pins: assert property (
    !flash_oe_n_out |-> !flash_ce_n_out && flash_we_n_out) else $error("bad read");
  a_write_pins: assert property (
    !flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out) else $error("bad write");
  a_bus_turn: assert property (
    !flash_oe_n_out |-> data_bus_oe_n_out) else $error("bus clash");
  a_reset_quiet: assert property (
    !flash_reset_n_out |-> flash_we_n_out && flash_oe_n_out) else $error("reset io");
  a_reset_width: assert property (
    $fell(flash_reset_n_out) |-> !flash_reset_n_out [*8]) else $error("short reset");
  a_release_wait: assert property (
    $rose(flash_reset_n_out) |-> flash_oe_n_out [*7]) else $error("early read");
  a_boost_use: assert property (
    fast_program_hv_pin_out |-> flash_oe_n_out) else $error("boost on read");
  a_valid_src: assert property (
    rd_valid_out |-> !flash_oe_n_out || $past(!flash_oe_n_out)) else $error("no read");
endmodule : pfb_monitor
bind pfb_host pfb_monitor mon_u (.*);
`default_nettype wire

// File: tb/pfb_flash_model.sv
// partner: behavioural flash device answering host pin cycles
`timescale 1ns/1ps
`default_nettype none
module pfb_flash_model (
  input  wire logic                       ce_n_in,
  input  wire logic                       oe_n_in,
  input  wire logic                       we_n_in,
  input  wire logic                       reset_n_in,
  input  wire logic [pfb_pkg::ADDR_W-1:0] addr_in,
  output logic      [pfb_pkg::DATA_W-1:0] dq_out,
  output logic                            ready_busy_n_out
);
  logic [18:0] open_page = 19'h0_0000;
  logic        page_open = 1'b0;
  logic        sel       = 1'b0;
  logic [7:0]  arr       = 8'h00;
  int unsigned tok       = 0;
  int unsigned dly       = 0;
  time         t_start   = 0;
  // no embedded operation is modelled, so always ready
  assign ready_busy_n_out = 1'b1;
  // command writes are taken and leave the array pattern
  initial dq_out = 8'h00;
  always @(ce_n_in or oe_n_in or we_n_in or reset_n_in or addr_in) begin
    // array read pattern with no command needed
    arr = addr_in[7:0] ^ addr_in[15:8] ^ {2'b00, addr_in[21:16]};
    sel = !ce_n_in && !oe_n_in && we_n_in && reset_n_in;
    tok = tok + 1;
    // deselect or reset closes the page, outputs float
    if (ce_n_in || !reset_n_in) page_open = 1'b0;
    // float and unsettled data shown as inverted data
    dq_out = ~arr;
    if (sel) begin
      // fast only inside the page left open
      if ($time != t_start) begin
        dly = (page_open && addr_in[21:3] == open_page) ?
              pfb_pkg::PAGE_ACCESS_NS : pfb_pkg::RANDOM_ACCESS_NS;
        t_start = $time;
      end
      open_page = addr_in[21:3];
      page_open = 1'b1;
      fork
        automatic int unsigned my_tok  = tok;
        automatic int unsigned wait_ns = dly;
        begin
          #(wait_ns);
          // data then stays latched until inputs move
          if (my_tok == tok) dq_out = arr;
        end
      join_none
    end
  end
endmodule : pfb_flash_model
`default_nettype wire

// File: tb/tb_top.sv
// testbench: random and corner reads, writes, boost and flash reset
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0, resetn_in = 1'b0, rd_req_in = 1'b0, wr_req_in = 1'b0;
  logic flash_reset_req_in = 1'b0, boost_req_in = 1'b0, ready_busy_n_in;
  logic [pfb_pkg::ADDR_W-1:0] addr_in = '0, flash_addr_out;
  logic [7:0] wdata_in = 8'h00, rdata_out, data_bus_out, dq_dev;
  logic ready_out, rd_valid_out, reset_done_out, dev_busy_out, flash_ce_n_out;
  logic flash_oe_n_out, flash_we_n_out, flash_reset_n_out;
  logic fast_program_hv_pin_out, data_bus_oe_n_out;
  wire [7:0] data_bus_in = data_bus_oe_n_out ? dq_dev : data_bus_out;
  int errors = 0, samples_checked = 0;
  pfb_host #(.RESET_SETTLE_CYCLES(20)) dut_u (.*);
  pfb_flash_model dev_u (.ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
    .we_n_in(flash_we_n_out), .reset_n_in(flash_reset_n_out),
    .addr_in(flash_addr_out), .dq_out(dq_dev), .ready_busy_n_out(ready_busy_n_in));
  initial forever #4 clk_in = ~clk_in;
  function automatic logic [7:0] exp_data(input logic [21:0] a);
    return a[7:0] ^ a[15:8] ^ {2'b00, a[21:16]};
  endfunction : exp_data
  task automatic end_of_test;
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wt(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
      if (n > 4000) begin
        errors++;
        end_of_test();
      end
    end while (!(s == 0 ? ready_out === 1'b1 :
                 s == 1 ? rd_valid_out === 1'b1 : reset_done_out === 1'b1));
  endtask : wt
  task automatic go(input int k, input logic [21:0] a);
    wt(0);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= 8'($urandom);
    {flash_reset_req_in, rd_req_in, wr_req_in} <= {k == 2, k == 1, k == 0};
    @(posedge clk_in);
    {flash_reset_req_in, rd_req_in, wr_req_in} <= 3'b000;
    if (k != 0) wt(k);
    if (k == 1) chk(rdata_out, exp_data(a));
  endtask : go
  initial begin
    void'($urandom(32'h3787_9bb2));
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    // top page, every byte back to back
    for (int i = 0; i < 8; i++) go(1, 22'h3F_FFF8 + 22'(i));
    for (int i = 0; i < 16; i++) go(1, 22'($urandom));
    boost_req_in <= 1'b1;
    go(0, 22'h00_0AAA);
    go(0, 22'($urandom));
    boost_req_in <= 1'b0;
    go(1, 22'h00_0AAA);
    go(2, 22'h00_0000);
    go(1, 22'h00_0007);
    chk({7'h00, dev_busy_out}, 8'h00);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
